//--- bench/two_wire_eeprom_slave_write_tb.sv
// self-checking bench of the two-wire eeprom slave against an array model
module two_wire_eeprom_slave_write_tb;
    import tws_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned WR = 50;
    localparam logic [3:0]  DT = 4'h5;  // arbitrary type code

    logic       ref_clk = 1'b0;
    logic       srst;  // starts unknown so its rise clears the start/stop toggles
    logic [1:0] pins    = 2'h0;
    wire  logic scl, pull, sda, sda_out, sda_oe, write_busy;
    logic [7:0] mem [0:511];  // model array
    int         ptr;          // model address counter
    int         bcnt = 0;
    int         blen = 0;
    int         errors = 0;
    int         total_checks = 0;

    always #5 ref_clk = ~ref_clk;

    tws_master u_mst (.sda(sda), .scl(scl), .pull(pull));

    // open-drain wire with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & ~pull;

    tws_eeprom_slave #(.WR_CYCLES(WR), .DEV_TYPE(DT)) u_dut (
        .ref_clk(ref_clk), .srst(srst), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pin_high(pins[1]),
        .chip_select_pin_low(pins[0]), .write_busy(write_busy));

    // length of the last busy period in reference clocks
    always @(posedge ref_clk) begin
        if (write_busy === 1'b1) begin
            bcnt <= bcnt + 1;
        end else if (bcnt != 0) begin
            blen <= bcnt;
            bcnt <= 0;
        end
    end

    // ========================================
    // checking and closing
    task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // ========================================
    // transactions
    task automatic sel(input logic pg, input logic rd, output logic ack);
        u_mst.start();
        u_mst.wr_byte({DT, pins, pg, rd}, ack);
    endtask : sel

    // page write, busy period, then polling until acknowledged
    task automatic wpage(input logic pg, input logic [7:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        sel(pg, 1'b0, ack);
        check("addr ack", 1, ack);
        u_mst.wr_byte(a, ack);
        check("word ack", 1, ack);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            u_mst.wr_byte(d, ack);
            check("data ack", 1, ack);
            mem[{pg, a[7:3], 3'(a[2:0] + k)}] = d;
        end
        ptr = {pg, a[7:3], 3'(a[2:0] + n)};
        u_mst.stop();
        for (int i = 0; i < 20 && write_busy !== 1'b1; i++) @(negedge ref_clk);
        check("busy", 1, write_busy);
        sel(pg, 1'b0, ack);
        check("busy ack", 0, ack);
        u_mst.stop();
        for (int i = 0; i < 40 && !ack; i++) begin
            sel(pg, 1'b0, ack);
            u_mst.stop();
        end
        check("poll ack", 1, ack);
        check("busy len", 9'(WR), 9'(blen));
    endtask : wpage

    // sequential read from the counter, master refuses the last byte
    task automatic rseq(input logic pg, input int n);
        logic       ack;
        logic [7:0] d;
        ptr = {pg, ptr[7:0]};
        sel(pg, 1'b1, ack);
        check("read addr ack", 1, ack);
        for (int k = 0; k < n; k++) begin
            u_mst.rd_byte(d, k < n - 1);
            check("read data", mem[ptr], d);
            ptr = {pg, 8'(ptr[7:0] + 1)};
        end
        check("released", 0, sda_oe);
        check("sda out", 0, sda_out);
        u_mst.stop();
    endtask : rseq

    // ========================================
    // main sequence
    initial begin
        logic ack;
        // late update so the asynchronous toggle resets see a rising edge
        srst <= 1'b1;
        void'($urandom(32'ha274fa24));
        pins = 2'($urandom);
        // scl edges carry the reset into the link domain during the hold
        fork
            repeat (3) u_mst.slot(1'b1, ack);
            repeat (16) @(posedge ref_clk);
        join
        #1 srst = 1'b0;
        repeat (3) u_mst.slot(1'b1, ack);
        // wrong type code or strap bits, later byte ignored too
        for (int i = 0; i < 6; i++) begin
            u_mst.start();
            u_mst.wr_byte({DT, pins, 2'h0} ^ (8'h80 >> i), ack);
            check("foreign ack", 0, ack);
            u_mst.wr_byte(8'h00, ack);
            check("ignored ack", 0, ack);
            u_mst.stop();
        end
        // partial byte cut by a fresh start
        u_mst.start();
        repeat (3) u_mst.slot(1'b0, ack);
        sel(1'b0, 1'b0, ack);
        check("restart ack", 1, ack);
        u_mst.stop();
        // ten bytes wrap inside the top block, then the bottom block
        for (int p = 0; p < 2; p++) begin
            wpage(p[0], {5'h1f, 3'($urandom)}, 10);
            wpage(p[0], 8'h00, 8);
        end
        // random read across the page end, then current address read
        for (int p = 0; p < 2; p++) begin
            sel(p[0], 1'b0, ack);
            u_mst.wr_byte(8'hfc, ack);
            check("dummy ack", 1, ack);
            ptr = {p[0], 8'hfc};
            rseq(p[0], 10);
            rseq(p[0], 1);
        end
        results();
    end

    // watchdog against a hung bus
    initial begin
        #500000;
        errors++;
        results();
    end
endmodule : two_wire_eeprom_slave_write_tb

//--- bench/tws_master.sv
// two-wire bus master model: scl runs only inside frames, sda pulled low or released
module tws_master (
    // resolved data line
    input  wire logic sda,
    // bus clock and data pull-down driven by the master
    output logic      scl,
    output logic      pull
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idles high with scl standing still
    initial begin
        scl  = 1'b1;
        pull = 1'b0;
    end

    // ========================================
    // bus primitives, 32 ns per bit slot
    // data set while scl low, held over the high phase, sampled mid-high
    task automatic slot(input logic b, output logic s);
        pull = ~b;
        #8 scl = 1'b1;
        #8 s = sda;
        #8 scl = 1'b0;
        #8;
    endtask : slot

    // sda falls with scl high, also used as a repeated start
    task automatic start();
        pull = 1'b0;
        #8 scl = 1'b1;
        #8 pull = 1'b1;
        #8 scl = 1'b0;
        #8;
    endtask : start

    // sda rises with scl high, then scl stands still
    task automatic stop();
        pull = 1'b1;
        #8 scl = 1'b1;
        #8 pull = 1'b0;
        #16;
    endtask : stop

    // eight bits msb first, then release and sample the acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], s);
        end
        slot(1'b1, s);
        ack = (s === 1'b0);
    endtask : wr_byte

    // receive eight bits, then acknowledge or not in the ninth slot
    task automatic rd_byte(output logic [7:0] d, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, d[i]);
        end
        slot(~ack, s);
    endtask : rd_byte
endmodule : tws_master

//--- rtl/tws_consts.svh
// constants of the two-wire eeprom slave: bit positions, sizes and timing
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// bit counter positions within one nine-clock byte slot
`define TWS_BIT_FIRST     4'h1
`define TWS_BIT_LAST      4'h7
`define TWS_BIT_ACK       4'h8

// page write buffer and array geometry
`define TWS_PAGE_BYTES    8
`define TWS_MEM_WORDS     512

// self-timed write cycle: time in ns and reference clock period in ns
`define TWS_WR_TIME_NS    5000000
`define TWS_REF_PERIOD_NS 10

`endif

//--- rtl/tws_eeprom_slave.sv
// two-wire eeprom slave: 512 bytes in two pages, page write, self-timed write
`include "tws_consts.svh"

module tws_eeprom_slave
    import tws_pkg::*;
#(
    // write cycle length in reference clocks, shorten for simulation
    parameter int unsigned WR_CYCLES = `TWS_WR_TIME_NS / `TWS_REF_PERIOD_NS,
    // device type code; this value is arbitrary
    parameter logic [3:0]  DEV_TYPE  = 4'h5
) (
    // reference clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // two-wire bus, scl clocks the bus engine
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // static chip-select straps
    input  wire logic chip_select_pin_high,
    input  wire logic chip_select_pin_low,
    // status
    output logic      write_busy
);

    localparam int CW = $clog2(WR_CYCLES + 1);

    // ==========================================================
    // crossings and pin synchronisers
    // ==========================================================
    logic       link_rst;
    logic [1:0] cs_s;
    logic       busy_s;
    logic       start_tog;
    logic       stop_tog;
    logic       stop_s;
    logic       wr_pend_s;
    logic       wr_pend_r;
    logic       busy_r;

    // reset into the scl domain
    tws_sync2 #(.W(1)) u_rst_sync (
        .clk (scl),
        .d   (srst),
        .q   (link_rst)
    );

    // straps are static pins, synchronised before use
    tws_sync2 #(.W(2)) u_cs_sync (
        .clk (scl),
        .d   ({chip_select_pin_high, chip_select_pin_low}),
        .q   (cs_s)
    );

    // write cycle state seen by the bus engine
    tws_sync2 #(.W(1)) u_busy_sync (
        .clk (scl),
        .d   (busy_r),
        .q   (busy_s)
    );

    // stop toggle and pending write seen by the timer
    tws_sync2 #(.W(2)) u_ref_sync (
        .clk (ref_clk),
        .d   ({stop_tog, wr_pend_r}),
        .q   ({stop_s, wr_pend_s})
    );

    // start and stop detection on the raw lines
    tws_sda_edge u_edge (
        .scl       (scl),
        .sda_in    (sda_in),
        .srst      (srst),
        .start_tog (start_tog),
        .stop_tog  (stop_tog)
    );

    // ==========================================================
    // bus engine, scl domain
    // ==========================================================
    tws_state_e state_r;
    logic [3:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic       ack_go_r;
    logic [7:0] addr_cnt_r;
    logic       page_r;
    logic       rd_mode_r;
    logic [7:0] tx_r;
    logic [5:0] wr_base_r;
    logic       start_seen_r;
    logic       stop_seen_r;
    logic       sda_oe_r;
    logic       busy_seen_r;
    logic [7:0] mem [`TWS_MEM_WORDS];
    logic [7:0] pbuf [`TWS_PAGE_BYTES];
    logic [`TWS_PAGE_BYTES-1:0] pbuf_vld_r;

    logic       start_pend;
    logic       stop_pend;
    logic [7:0] byte_in;
    tws_addr_s  addr_in;
    logic       addr_match;
    logic [7:0] mem_rd;
    logic       wr_byte_done;
    logic       commit;

    // events not yet taken by the engine
    assign start_pend = start_tog ^ start_seen_r;
    assign stop_pend  = stop_tog ^ stop_seen_r;

    // byte as completed by the current sample
    assign byte_in    = {shift_r, sda_in};
    assign addr_in    = tws_addr_s'(byte_in);
    assign addr_match = (addr_in.dev_type == DEV_TYPE)
                      && (addr_in.cs_high == cs_s[1])
                      && (addr_in.cs_low == cs_s[0]);

    // array read at the page and address counter
    assign mem_rd       = mem[{page_r, addr_cnt_r}];
    assign wr_byte_done = (state_r == TWS_WRDATA) && (bit_cnt_r == `TWS_BIT_LAST)
                        && !start_pend && !stop_pend;
    // commit once the timer has run and finished
    assign commit       = wr_pend_r && busy_seen_r && !busy_s;

    // take start and stop events
    always_ff @(posedge scl) begin
        if (link_rst) begin
            start_seen_r <= start_tog;
            stop_seen_r  <= stop_tog;
        end else begin
            start_seen_r <= start_tog;
            stop_seen_r  <= stop_tog;
        end
    end

    // protocol sequencing, sampled on rising scl
    always_ff @(posedge scl) begin
        if (link_rst) begin
            state_r    <= TWS_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 7'h00;
            ack_go_r   <= 1'b0;
            addr_cnt_r <= 8'h00;
            page_r     <= 1'b0;
            rd_mode_r  <= 1'b0;
            tx_r       <= 8'h00;
            wr_base_r  <= 6'h00;
        end else if (start_pend) begin
            state_r   <= TWS_DEVADDR;
            shift_r   <= {6'h00, sda_in};
            bit_cnt_r <= `TWS_BIT_FIRST;
            ack_go_r  <= 1'b0;
        end else if (stop_pend) begin
            state_r   <= TWS_IDLE;
            bit_cnt_r <= 4'h0;
            ack_go_r  <= 1'b0;
        end else begin
            unique case (state_r)
                TWS_IDLE, TWS_WAIT: begin
                    bit_cnt_r <= 4'h0;
                end
                TWS_DEVADDR, TWS_WORDADDR, TWS_WRDATA: begin
                    if (bit_cnt_r == `TWS_BIT_ACK) begin
                        bit_cnt_r <= 4'h0;
                        ack_go_r  <= 1'b0;
                        if (!ack_go_r) begin
                            state_r <= TWS_WAIT;
                        end else if (state_r == TWS_DEVADDR) begin
                            state_r <= rd_mode_r ? TWS_RDDATA : TWS_WORDADDR;
                            tx_r    <= mem_rd;
                        end else if (state_r == TWS_WORDADDR) begin
                            state_r <= TWS_WRDATA;
                        end
                    end else begin
                        shift_r   <= byte_in[6:0];
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `TWS_BIT_LAST) begin
                            if (state_r == TWS_DEVADDR) begin
                                ack_go_r <= addr_match && !wr_pend_r;
                                if (addr_match) begin
                                    page_r    <= addr_in.page;
                                    rd_mode_r <= addr_in.rd;
                                end
                            end else if (state_r == TWS_WORDADDR) begin
                                ack_go_r   <= 1'b1;
                                addr_cnt_r <= byte_in;
                                wr_base_r  <= {page_r, byte_in[7:3]};
                            end else begin
                                ack_go_r   <= 1'b1;
                                addr_cnt_r <= {addr_cnt_r[7:3], addr_cnt_r[2:0] + 3'h1};
                            end
                        end
                    end
                end
                TWS_RDDATA: begin
                    if (bit_cnt_r == `TWS_BIT_ACK) begin
                        if (!sda_in) begin
                            tx_r      <= mem_rd;
                            bit_cnt_r <= 4'h0;
                        end else begin
                            state_r <= TWS_WAIT;
                        end
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `TWS_BIT_LAST) begin
                            addr_cnt_r <= addr_cnt_r + 8'h01;
                        end
                    end
                end
            endcase
        end
    end

    // sda drive, changed on falling scl only; pulls low or releases
    always_ff @(negedge scl) begin
        if (link_rst || start_pend) begin
            sda_oe_r <= 1'b0;
        end else begin
            unique case (state_r)
                TWS_DEVADDR, TWS_WORDADDR, TWS_WRDATA: begin
                    sda_oe_r <= (bit_cnt_r == `TWS_BIT_ACK) && ack_go_r;
                end
                TWS_RDDATA: begin
                    sda_oe_r <= (bit_cnt_r != `TWS_BIT_ACK)
                              && !tx_r[3'h7 - bit_cnt_r[2:0]];
                end
                TWS_IDLE, TWS_WAIT: begin
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    assign sda_oe  = sda_oe_r;
    assign sda_out = 1'b0;

    // page buffer: each data byte lands at its low address bits
    always_ff @(posedge scl) begin
        if (link_rst) begin
            pbuf_vld_r <= '0;
        end else if (wr_byte_done) begin
            pbuf[addr_cnt_r[2:0]]       <= byte_in;
            pbuf_vld_r[addr_cnt_r[2:0]] <= 1'b1;
        end else if (commit) begin
            pbuf_vld_r <= '0;
        end
    end

    // pending write: a set wins over the commit clear
    always_ff @(posedge scl) begin
        if (link_rst) begin
            wr_pend_r <= 1'b0;
        end else if (wr_byte_done) begin
            wr_pend_r <= 1'b1;
        end else if (commit) begin
            wr_pend_r <= 1'b0;
        end
    end

    // timer seen running for the pending write
    always_ff @(posedge scl) begin
        if (link_rst || commit) begin
            busy_seen_r <= 1'b0;
        end else if (busy_s) begin
            busy_seen_r <= 1'b1;
        end
    end

    // program the array once the write cycle has elapsed
    always_ff @(posedge scl) begin
        if (commit) begin
            for (int i = 0; i < `TWS_PAGE_BYTES; i++) begin
                if (pbuf_vld_r[i]) begin
                    mem[{wr_base_r, 3'(i)}] <= pbuf[i];
                end
            end
        end
    end

    // ==========================================================
    // write cycle timer, reference domain
    // ==========================================================
    logic          stop_d_r;
    logic          done_wait_r;
    logic [CW-1:0] wr_cnt_r;
    logic          stop_evt;
    logic          wr_last;

    assign stop_evt   = stop_s ^ stop_d_r;
    assign wr_last    = busy_r && (wr_cnt_r == CW'(WR_CYCLES - 1));
    assign write_busy = busy_r;

    // stop edge detection
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stop_d_r <= 1'b0;
        end else begin
            stop_d_r <= stop_s;
        end
    end

    // busy window counted from the stop that ends a write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_r   <= 1'b0;
            wr_cnt_r <= '0;
        end else if (busy_r) begin
            if (wr_last) begin
                busy_r   <= 1'b0;
                wr_cnt_r <= '0;
            end else begin
                wr_cnt_r <= wr_cnt_r + CW'(1);
            end
        end else if (stop_evt && wr_pend_s && !done_wait_r) begin
            busy_r <= 1'b1;
        end
    end

    // hold off a second start until the engine has committed
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            done_wait_r <= 1'b0;
        end else if (wr_last) begin
            done_wait_r <= 1'b1;
        end else if (!wr_pend_s) begin
            done_wait_r <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    chk_busy_start: assert property (@(posedge ref_clk) disable iff (srst)
        stop_evt && wr_pend_s && !busy_r && !done_wait_r |=> busy_r)
        else $error("write cycle did not start at stop");

    chk_busy_length: assert property (@(posedge ref_clk) disable iff (srst)
        $fell(busy_r) |-> $past(wr_cnt_r) == CW'(WR_CYCLES - 1))
        else $error("write cycle length wrong");

    chk_nack_busy: assert property (@(posedge scl) disable iff (link_rst)
        state_r == TWS_DEVADDR && bit_cnt_r == `TWS_BIT_LAST && wr_pend_r
        && !start_pend && !stop_pend |=> !ack_go_r && !sda_oe_r)
        else $error("address acknowledged while busy");

    chk_addr_match: assert property (@(posedge scl) disable iff (link_rst)
        state_r == TWS_DEVADDR && bit_cnt_r == `TWS_BIT_LAST && addr_match
        && !wr_pend_r && !start_pend && !stop_pend |=> ack_go_r && sda_oe_r)
        else $error("matching address not acknowledged");

    chk_wait_release: assert property (@(posedge scl) disable iff (link_rst)
        state_r == TWS_WAIT && $past(state_r) == TWS_WAIT |-> !sda_oe_r)
        else $error("sda driven while ignoring bus");

    chk_wr_wrap: assert property (@(posedge scl) disable iff (link_rst)
        wr_byte_done |=> addr_cnt_r[7:3] == $past(addr_cnt_r[7:3])
        && addr_cnt_r[2:0] == $past(addr_cnt_r[2:0]) + 3'h1)
        else $error("page write address step wrong");

    chk_rd_incr: assert property (@(posedge scl) disable iff (link_rst)
        state_r == TWS_RDDATA && bit_cnt_r == `TWS_BIT_LAST && !start_pend && !stop_pend
        |=> addr_cnt_r == $past(addr_cnt_r) + 8'h01)
        else $error("read address step wrong");

    chk_rd_nack: assert property (@(posedge scl) disable iff (link_rst)
        state_r == TWS_RDDATA && bit_cnt_r == `TWS_BIT_ACK && sda_in
        && !start_pend && !stop_pend |=> state_r == TWS_WAIT ##1 !sda_oe_r)
        else $error("read did not stop after nack");

    chk_start_restart: assert property (@(posedge scl) disable iff (link_rst)
        start_pend |=> state_r == TWS_DEVADDR && bit_cnt_r == `TWS_BIT_FIRST)
        else $error("start did not restart addressing");

    cov_byte_write: cover property (@(posedge scl) disable iff (link_rst)
        wr_byte_done);
    cov_seq_read: cover property (@(posedge scl) disable iff (link_rst)
        state_r == TWS_RDDATA && bit_cnt_r == `TWS_BIT_ACK && !sda_in);
    cov_commit: cover property (@(posedge scl) disable iff (link_rst) commit);
    cov_busy_end: cover property (@(posedge ref_clk) disable iff (srst) $fell(busy_r));

endmodule : tws_eeprom_slave

//--- rtl/tws_pkg.sv
// types shared by the two-wire eeprom slave
package tws_pkg;

    // bus engine phases, gray coded along the write path
    typedef enum logic [2:0] {
        TWS_IDLE     = 3'h0,
        TWS_DEVADDR  = 3'h1,
        TWS_WORDADDR = 3'h3,
        TWS_WRDATA   = 3'h2,
        TWS_RDDATA   = 3'h6,
        TWS_WAIT     = 3'h7
    } tws_state_e;

    // fields of the slave address byte, msb first
    typedef struct packed {
        logic [3:0] dev_type;
        logic       cs_high;
        logic       cs_low;
        logic       page;
        logic       rd;
    } tws_addr_s;

endpackage : tws_pkg

//--- rtl/tws_sda_edge.sv
// start and stop detection: sda edges while scl is high flip a toggle each
module tws_sda_edge (
    // bus pins
    input  wire logic scl,
    input  wire logic sda_in,
    // reset from the reference domain, used asynchronously here
    input  wire logic srst,
    // event toggles
    output logic      start_tog,
    output logic      stop_tog
);

    // falling sda with scl high marks a start
    always_ff @(negedge sda_in or posedge srst) begin
        if (srst) begin
            start_tog <= 1'b0;
        end else if (scl) begin
            start_tog <= ~start_tog;
        end
    end

    // rising sda with scl high marks a stop
    always_ff @(posedge sda_in or posedge srst) begin
        if (srst) begin
            stop_tog <= 1'b0;
        end else if (scl) begin
            stop_tog <= ~stop_tog;
        end
    end

endmodule : tws_sda_edge

//--- rtl/tws_sync2.sv
// two flip-flop synchroniser for levels, parameterised width
module tws_sync2 #(
    parameter int W = 1
) (
    // clock of the receiving domain
    input  wire logic         clk,
    // level from another domain and its synchronised copy
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end

endmodule : tws_sync2
